// *** boe_pkg.sv ***
`default_nettype none

package boe_pkg;

	// ----------------------------------------
	// Widths and opcode fields
	// ----------------------------------------
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned ADDR_W     = 7;
	localparam int unsigned INSN_W     = 14;
	localparam int unsigned NIB_LO_MSB = 3;
	localparam int unsigned NIB_HI_LSB = 4;
	localparam int unsigned DEST_BIT   = 7;

	// Upper six opcode bits, insn[13:8]
	localparam logic [5:0] OPC_SUB   = 6'h02;
	localparam logic [5:0] OPC_XORF  = 6'h06;
	localparam logic [5:0] OPC_SWAP  = 6'h0e;
	localparam logic [5:0] OPC_XORL  = 6'h3a;
	// Direction load: 00 0000 0110 0fff
	localparam logic [10:0] OPC_DIR  = 11'h00c;
	localparam logic [2:0]  DIR_LO   = 3'h5;
	localparam logic [2:0]  DIR_HI   = 3'h7;
	localparam int unsigned DIR_N    = 3;

	// Direction registers directly addressable at these file addresses
	localparam logic [6:0] DIR_ADDR0 = 7'h05;

	// Status bit positions inside the status byte
	localparam int unsigned ST_C  = 0;
	localparam int unsigned ST_DC = 1;
	localparam int unsigned ST_Z  = 2;

	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hff;

	// Four oscillator periods per instruction cycle
	localparam int unsigned PHASES = 4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		PH_DECODE  = 4'h1,
		PH_READ    = 4'h2,
		PH_PROCESS = 4'h4,
		PH_WRITE   = 4'h8
	} boe_phase_type;

	typedef enum logic [5:0] {
		OP_NONE = 6'h01,
		OP_SWAP = 6'h02,
		OP_XORF = 6'h04,
		OP_XORL = 6'h08,
		OP_SUB  = 6'h10,
		OP_DIR  = 6'h20
	} boe_op_type;

	typedef struct packed {
		logic       wr_en;
		logic [6:0] addr;
		logic [7:0] data;
	} boe_file_wr_type;

	typedef struct packed {
		logic       c;
		logic       dc;
		logic       z;
	} boe_flags_type;

endpackage

`default_nettype wire

// *** boe_alu.sv ***
`timescale 1ns/1ps
`default_nettype none

module boe_alu (
	// Operation and operands
	input  wire boe_pkg::boe_op_type    op,
	input  wire logic [7:0]             acc,
	input  wire logic [7:0]             opnd,
	input  wire boe_pkg::boe_flags_type flags_in,
	// Result
	output logic [7:0]                  result,
	output boe_pkg::boe_flags_type      flags_out
);

	logic [8:0] diff;
	logic [4:0] ldiff;

	// Two's complement: operand plus inverted accumulator plus one
	assign diff  = {1'b0, opnd} + {1'b0, ~acc} + 9'h001; // RQ8
	assign ldiff = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

	// Result and flag selection
	always_comb begin
		result    = opnd;
		flags_out = flags_in;
		case (op)
			boe_pkg::OP_SWAP: begin
				result = {opnd[boe_pkg::NIB_LO_MSB:0], opnd[7:boe_pkg::NIB_HI_LSB]}; // RQ1
			end
			boe_pkg::OP_XORF, boe_pkg::OP_XORL: begin
				result      = acc ^ opnd; // RQ4 RQ5
				flags_out.z = ((acc ^ opnd) == 8'h00);
			end
			boe_pkg::OP_SUB: begin
				result       = diff[7:0];
				flags_out.c  = diff[8]; // RQ9
				flags_out.dc = ldiff[4];
				flags_out.z  = (diff[7:0] == 8'h00); // RQ9
			end
			boe_pkg::OP_DIR: begin
				result = acc; // RQ3
			end
			default: begin
				result = opnd;
			end
		endcase
	end

endmodule

`default_nettype wire

// *** boe_core.sv ***
// What this block does
// [RQ1] Nibble swap exchanges halves, flags untouched
// [RQ2] Destination bit 0 to accumulator, 1 to file
// [RQ3] Direction load copies accumulator, ports 5 to 7
// [RQ4] Literal XOR into accumulator, zero flag only
// [RQ5] File XOR routed by destination, zero only
// [RQ6] Four phases: decode, read, process, write
// [RQ7] Fully static: state held while clock stops
// [RQ8] Subtract accumulator from file, update C DC Z
// [RQ9] Carry means no borrow; zero on zero
`timescale 1ns/1ps
`default_nettype none

module boe_core (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	// Oscillator period enable
	input  wire logic                   osc_en,
	// Instruction from decoder
	input  wire logic                   insn_valid,
	input  wire logic [13:0]            insn,
	// File register read port
	output logic [6:0]                  file_rd_addr,
	input  wire logic [7:0]             file_rd_data,
	// File register write port
	output boe_pkg::boe_file_wr_type    file_wr,
	// Status flags from and to the status register
	input  wire boe_pkg::boe_flags_type status_in,
	output boe_pkg::boe_flags_type      status_out,
	output logic                        status_wr,
	// Architectural state
	output logic [7:0]                  acc_out,
	output logic [23:0]                 dir_out,
	output boe_pkg::boe_phase_type      phase_out,
	output logic                        cycle_done
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		boe_pkg::boe_phase_type   phase;
		boe_pkg::boe_op_type      op;
		logic                     dest;
		logic [6:0]               addr;
		logic [7:0]               opnd;
		logic [7:0]               res;
		boe_pkg::boe_flags_type   flg;
		logic [7:0]               acc;
		logic [23:0]              dir;
		logic [6:0]               rd_addr;
		boe_pkg::boe_file_wr_type fwr;
		boe_pkg::boe_flags_type   st;
		logic                     st_wr;
		logic                     done;
	} boe_state_type;

	boe_state_type              st_r;
	boe_state_type              st_nxt;
	logic [7:0]                 alu_res;
	boe_pkg::boe_flags_type     alu_flg;
	boe_pkg::boe_op_type        dec_op;
	// Per-port direction write selects and the merged next value
	logic [boe_pkg::DIR_N-1:0]  dir_load;
	logic [boe_pkg::DIR_N-1:0]  dir_file;
	logic [23:0]                dir_upd;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Opcode classes from the upper instruction bits; anything not listed,
	// including a direction load outside ports 5 to 7, falls through to a
	// no-op that still runs all four phases
	always_comb begin
		dec_op = boe_pkg::OP_NONE;
		if (insn[13:8] == boe_pkg::OPC_SWAP) begin
			dec_op = boe_pkg::OP_SWAP;
		end else if (insn[13:8] == boe_pkg::OPC_XORF) begin
			dec_op = boe_pkg::OP_XORF;
		end else if (insn[13:8] == boe_pkg::OPC_XORL) begin
			dec_op = boe_pkg::OP_XORL;
		end else if (insn[13:8] == boe_pkg::OPC_SUB) begin
			dec_op = boe_pkg::OP_SUB;
		end else if (insn[13:3] == boe_pkg::OPC_DIR && insn[2:0] >= boe_pkg::DIR_LO
			&& insn[2:0] <= boe_pkg::DIR_HI) begin
			dec_op = boe_pkg::OP_DIR; // RQ3
		end
	end

	// Arithmetic and logic; untouched flags fall back to the live status input
	boe_alu u_alu (
		.op        (st_r.op),
		.acc       (st_r.acc),
		.opnd      (st_r.opnd),
		.flags_in  (status_in),
		.result    (alu_res),
		.flags_out (alu_flg)
	);

	// ----------------------------------------
	// Direction register lanes
	// ----------------------------------------
	// Each port owns one byte lane of the direction bank. Two paths reach it:
	// the legacy load names the port by its three-bit operand, and ordinary
	// file-destination results name it by its file address.
	for (genvar gi = 0; gi < boe_pkg::DIR_N; gi++) begin : g_dir
		// Legacy load: operand 5, 6, 7 selects lane 0, 1, 2
		assign dir_load[gi] = (st_r.op == boe_pkg::OP_DIR)
			&& (st_r.addr[2:0] == boe_pkg::DIR_LO + 3'(gi)); // RQ3
		// Direct write: the register stays addressable as a file register
		assign dir_file[gi] = st_r.dest
			&& (st_r.op == boe_pkg::OP_SWAP || st_r.op == boe_pkg::OP_XORF || st_r.op == boe_pkg::OP_SUB)
			&& (st_r.addr == boe_pkg::DIR_ADDR0 + 7'(gi)); // RQ3
		// Lane keeps its value unless one of the two paths selects it
		assign dir_upd[gi * boe_pkg::DATA_W +: boe_pkg::DATA_W] = (dir_load[gi] || dir_file[gi])
			? st_r.res : st_r.dir[gi * boe_pkg::DATA_W +: boe_pkg::DATA_W];
	end

	// ----------------------------------------
	// Phase sequencer and datapath
	// ----------------------------------------
	// Every step is gated by osc_en, so a stopped oscillator freezes all state.
	// Nothing here counts time: no timeout and no refresh, so the enable may
	// stay low as long as the system likes and the cycle resumes where it left.
	// Write, status and done strobes drop back on the next clock either way.
	always_comb begin
		st_nxt           = st_r; // RQ7
		st_nxt.fwr.wr_en = 1'b0;
		st_nxt.st_wr     = 1'b0;
		st_nxt.done      = 1'b0;
		if (osc_en) begin
			case (st_r.phase)
				boe_pkg::PH_DECODE: begin
					// Instruction word is only looked at here; the decoder may change
					// it freely during the other three phases
					st_nxt.op      = insn_valid ? dec_op : boe_pkg::OP_NONE;
					st_nxt.dest    = insn[boe_pkg::DEST_BIT];
					st_nxt.addr    = insn[6:0];
					st_nxt.opnd    = insn[7:0];
					st_nxt.rd_addr = insn[6:0];
					st_nxt.phase   = boe_pkg::PH_READ; // RQ6
				end
				boe_pkg::PH_READ: begin
					// Literal operand already latched; file ops read the file.
					// The file read is combinational off file_rd_addr, which has
					// held the address since the decode edge.
					if (st_r.op != boe_pkg::OP_XORL) begin
						st_nxt.opnd = file_rd_data;
					end
					st_nxt.phase = boe_pkg::PH_PROCESS; // RQ6
				end
				boe_pkg::PH_PROCESS: begin
					// Result and flags are captured here so that the write phase
					// commits values that no longer depend on the file read port
					st_nxt.res   = alu_res;
					st_nxt.flg   = alu_flg;
					st_nxt.phase = boe_pkg::PH_WRITE; // RQ6
				end
				boe_pkg::PH_WRITE: begin
					// Commit step: at most one of accumulator and file is written, chosen by the
					// destination bit for file ops; literal XOR always writes the accumulator
					case (st_r.op)
						boe_pkg::OP_SWAP, boe_pkg::OP_XORF, boe_pkg::OP_SUB: begin
							if (st_r.dest) begin
								st_nxt.fwr = '{wr_en: 1'b1, addr: st_r.addr, data: st_r.res}; // RQ2
							end else begin
								st_nxt.acc = st_r.res; // RQ2
							end
							// Swap leaves status alone
							st_nxt.st_wr = (st_r.op != boe_pkg::OP_SWAP); // RQ1 RQ5 RQ8
							st_nxt.st    = st_r.flg;
						end
						boe_pkg::OP_XORL: begin
							st_nxt.acc   = st_r.res; // RQ4
							st_nxt.st_wr = 1'b1;
							st_nxt.st    = st_r.flg;
						end
						boe_pkg::OP_DIR: begin
							// Lane chosen in g_dir; status is left alone
							st_nxt.st_wr = 1'b0; // RQ3
						end
						default: begin
							st_nxt.st_wr = 1'b0;
						end
					endcase
					// Direction bank takes the merged lanes, unchanged where nothing hit
					st_nxt.dir = dir_upd; // RQ3
					st_nxt.done  = 1'b1;
					st_nxt.phase = boe_pkg::PH_DECODE; // RQ6
				end
				default: begin
					st_nxt.phase = boe_pkg::PH_DECODE;
				end
			endcase
		end
	end

	// State register; reset puts the sequencer back in decode with a clean
	// accumulator and every port direction at its reset value
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r       <= '0;
			st_r.phase <= boe_pkg::PH_DECODE;
			st_r.op    <= boe_pkg::OP_NONE;
			st_r.acc   <= boe_pkg::ACC_RST;
			st_r.dir   <= {boe_pkg::DIR_N{boe_pkg::DIR_RST}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from state, so every pin of the block is a flip-flop
	// and nothing downstream sees a combinational path through the datapath
	assign file_rd_addr = st_r.rd_addr;
	assign file_wr      = st_r.fwr;
	assign status_out   = st_r.st;
	assign status_wr    = st_r.st_wr;
	assign acc_out      = st_r.acc;
	assign dir_out      = st_r.dir;
	assign phase_out    = st_r.phase;
	assign cycle_done   = st_r.done;

endmodule

`default_nettype wire

// *** boe_core_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module boe_core_sva (
	// Clock and reset
	input wire logic                     clk_sys,
	input wire logic                     srst,
	// Watched ports
	input wire logic                     osc_en,
	input wire logic                     insn_valid,
	input wire logic [13:0]              insn,
	input wire boe_pkg::boe_file_wr_type file_wr,
	input wire logic                     status_wr,
	input wire logic [7:0]               acc_out,
	input wire logic [23:0]              dir_out,
	input wire boe_pkg::boe_phase_type   phase_out,
	input wire logic                     cycle_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Literal XOR result lands three phases after decode
	property p_xorl;
		logic [7:0] k, a;
		(osc_en && phase_out == boe_pkg::PH_DECODE && insn_valid && insn[13:8] == boe_pkg::OPC_XORL,
			k = insn[7:0], a = acc_out) ##1 osc_en [*3] |=> acc_out == (a ^ k) && !file_wr.wr_en;
	endproperty
	// Swap never writes status
	sequence s_swap;
		osc_en && phase_out == boe_pkg::PH_DECODE && insn_valid && insn[13:8] == boe_pkg::OPC_SWAP;
	endsequence
	a_xorl_result: assert property (p_xorl) else $error("literal xor result wrong");
	a_swap_flags: assert property (s_swap ##1 osc_en [*3] |=> !status_wr) else $error("swap wrote status");
	a_decode_read: assert property (osc_en && phase_out == boe_pkg::PH_DECODE
		|=> phase_out == boe_pkg::PH_READ) else $error("decode not followed by read");
	a_read_process: assert property (osc_en && phase_out == boe_pkg::PH_READ
		|=> phase_out == boe_pkg::PH_PROCESS) else $error("read not followed by process");
	a_write_wrap: assert property (osc_en && phase_out == boe_pkg::PH_WRITE
		|=> phase_out == boe_pkg::PH_DECODE && cycle_done) else $error("write phase did not end cycle");
	a_stop_hold: assert property (!osc_en |=> $stable(phase_out) && $stable(acc_out) && $stable(dir_out))
		else $error("state moved with clock stopped");
	a_done_cause: assert property (cycle_done |-> $past(osc_en) && $past(phase_out) == boe_pkg::PH_WRITE)
		else $error("cycle end without write phase");
	a_wr_pulse: assert property (file_wr.wr_en |-> cycle_done ##1 !file_wr.wr_en)
		else $error("file write not single pulse");
	a_status_end: assert property (status_wr |-> cycle_done) else $error("status write off cycle end");
	c_file_wr: cover property (file_wr.wr_en);
	c_status: cover property (status_wr);
	c_stall: cover property (!osc_en && phase_out == boe_pkg::PH_READ);
endmodule
`default_nettype wire

// *** byte_op_execute_unit_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module byte_op_execute_unit_test;
	typedef struct packed {
		logic [13:0] i;
		logic [7:0]  d, a;
		logic        w;
		logic [7:0]  wd;
		logic        s;
		logic [2:0]  st;
	} boe_row_type;
	logic clk_sys = 1'b0, srst = 1'b1, osc_en = 1'b0, insn_valid = 1'b0, status_wr, cycle_done;
	logic [13:0] insn = 14'h0000;
	logic [7:0] file_rd_data = 8'h00, acc_out;
	logic [6:0] file_rd_addr;
	logic [23:0] dir_out;
	boe_pkg::boe_file_wr_type file_wr;
	boe_pkg::boe_flags_type status_in = 3'h5, status_out;
	boe_pkg::boe_phase_type phase_out;
	boe_row_type rows [10];
	integer err_total = 0, num_checks = 0;
	boe_core boe_core_inst (.clk_sys(clk_sys), .srst(srst), .osc_en(osc_en), .insn_valid(insn_valid),
		.insn(insn), .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data), .file_wr(file_wr),
		.status_in(status_in), .status_out(status_out), .status_wr(status_wr), .acc_out(acc_out),
		.dir_out(dir_out), .phase_out(phase_out), .cycle_done(cycle_done));
	// Clock
	always #20 clk_sys = ~clk_sys;
	task automatic finish_test;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One instruction, held until its cycle ends; the enable stays high so that
	// a following call does not toggle it within one time step
	task automatic run(input logic [13:0] i, input logic [7:0] d);
		integer n;
		n = 0;
		insn = i;
		file_rd_data = d;
		insn_valid = 1'b1;
		osc_en = 1'b1;
		do begin
			@(negedge clk_sys);
			n++;
		end while (cycle_done !== 1'b1 && n < 20);
		if (cycle_done !== 1'b1) begin
			err_total++;
			finish_test;
		end
	endtask
	// Main sequence
	initial begin
		rows = '{'{14'h3ab5, 8'h00, 8'hb5, 1'b0, 8'h00, 1'b1, 3'h4}, '{14'h3aaf, 8'h00, 8'h1a, 1'b0, 8'h00, 1'b1, 3'h4},
			'{14'h0610, 8'h1a, 8'h00, 1'b0, 8'h00, 1'b1, 3'h5}, '{14'h3a02, 8'h00, 8'h02, 1'b0, 8'h00, 1'b1, 3'h4},
			'{14'h0291, 8'h03, 8'h02, 1'b1, 8'h01, 1'b1, 3'h6}, '{14'h0291, 8'h02, 8'h02, 1'b1, 8'h00, 1'b1, 3'h7},
			'{14'h0291, 8'h01, 8'h02, 1'b1, 8'hff, 1'b1, 3'h0}, '{14'h0e12, 8'ha5, 8'h5a, 1'b0, 8'h00, 1'b0, 3'h0},
			'{14'h0e92, 8'ha5, 8'h5a, 1'b1, 8'h5a, 1'b0, 3'h0}, '{14'h0693, 8'h5a, 8'h5a, 1'b1, 8'h00, 1'b1, 3'h5}};
		repeat (4) @(negedge clk_sys);
		srst = 1'b0;
		chk({acc_out, 4'h0, phase_out}, {8'h00, 4'h0, boe_pkg::PH_DECODE});
		chk(dir_out, 24'hffffff);
		foreach (rows[r]) begin
			run(rows[r].i, rows[r].d);
			chk(acc_out, rows[r].a);
			chk({file_wr.wr_en, file_wr.data & {8{file_wr.wr_en}}}, {rows[r].w, rows[r].wd});
			chk(status_wr, rows[r].s);
			if (rows[r].s) chk(status_out, rows[r].st);
			chk(file_rd_addr, rows[r].i[6:0]);
			if (rows[r].w) chk(file_wr.addr, rows[r].i[6:0]);
		end
		run(14'h0065, 8'h00);
		chk({status_wr, dir_out}, 25'h0ffff5a);
		run(14'h0067, 8'h00);
		chk(dir_out, 24'h5aff5a);
		run(14'h0064, 8'h00);
		chk({cycle_done, dir_out}, 25'h15aff5a);
		// Swap to file address 06 lands in the middle direction lane
		run(14'h0e86, 8'h12);
		chk({file_wr.wr_en, dir_out}, 25'h15a215a);
		// Stop the clock after decode, then resume
		insn = 14'h3aff;
		osc_en = 1'b1;
		@(negedge clk_sys);
		osc_en = 1'b0;
		repeat (50) @(negedge clk_sys);
		chk({acc_out, 4'h0, phase_out}, {8'h5a, 4'h0, boe_pkg::PH_READ});
		run(14'h3aff, 8'h00);
		chk(acc_out, 8'ha5);
		// Reset in mid-instruction, then one instruction right after release
		insn = 14'h3a0f;
		@(negedge clk_sys);
		srst = 1'b1;
		@(negedge clk_sys);
		srst = 1'b0;
		chk({cycle_done, acc_out, 4'h0, phase_out}, {1'b0, 8'h00, 4'h0, boe_pkg::PH_DECODE});
		chk(dir_out, 24'hffffff);
		run(14'h3a0f, 8'h00);
		chk(acc_out, 8'h0f);
		finish_test;
	end
endmodule
bind boe_core boe_core_sva boe_core_sva_inst (.clk_sys(clk_sys), .srst(srst), .osc_en(osc_en),
	.insn_valid(insn_valid), .insn(insn), .file_wr(file_wr), .status_wr(status_wr), .acc_out(acc_out),
	.dir_out(dir_out), .phase_out(phase_out), .cycle_done(cycle_done));
`default_nettype wire
